// ===== flb_ctrl.v
`include "flb_map.vh"
`default_nettype none

// What this block does
// - Short press, no fault: enter display
// - Display flashes channel one green 1-4
// - Four flashes 4.0A down to one 2.5A
// - Dual: then channel two, then exit
// - Long press simulates fault, yellow, relay
// - Short press or remote pulse clears log
// - Live ground fault blocks log clear
// - Second long press simulates channel two
// - Remote high 100 ms means reset
// - Remote low 100 ms re-arms reset
// - Power LED steady; 1 Hz when low
// - Power LED 4 Hz in setting mode if not low
// - No fault off/open; fault yellow/closed
// - Fault gone, logged: yellow 1 Hz, closed
// - Overload alone: red, relay open
// - Overload plus logged fault: red/yellow
// - Separate relay per channel
// - Relay closes at fault detection
// - Relay opens after fault gone and cleared
// - Short press clears both channels
// - Short press clears or displays
// - Long press from power-up sets limits
// - Short press steps limit cyclically
// - Long press stores, next channel, exit
module flb_ctrl #(
    parameter        DUAL    = 1,
    parameter [27:0] N_SHORT = `FLB_N(`FLB_T_SHORT_MS),
    parameter [27:0] N_LMIN  = `FLB_N(`FLB_T_LMIN_MS),
    parameter [27:0] N_LMAX  = `FLB_N(`FLB_T_LMAX_MS),
    parameter [27:0] N_REM   = `FLB_N(`FLB_T_REM_MS),
    parameter [27:0] N_1HZ   = `FLB_N(`FLB_T_1HZ_MS),
    // Derived, same ratios as the timing macros
    parameter [27:0] N_DEB   = N_REM / 28'h5,
    parameter [27:0] N_PWRUP = N_1HZ,
    parameter [27:0] N_4HZ   = N_1HZ / 28'h4
) (
    input  wire       sys_clk,                    // System clock
    input  wire       nrst,                       // Sync reset, low
    input  wire       button_pin,                 // Push-button, high pressed
    input  wire       remote_reset_pos,           // Remote reset level
    input  wire       supply_low_pin,             // Supply too low
    input  wire       gnd_fault_one_pin,          // Ground fault, ch one
    input  wire       gnd_fault_two_pin,          // Ground fault, ch two
    input  wire       overload_one_pin,           // Overload, ch one
    input  wire       overload_two_pin,           // Overload, ch two
    output wire       power_indicator,            // Power LED green
    output wire [2:0] channel_one_status_led,     // {green,red,yellow}
    output wire [2:0] channel_two_status_led,     // {green,red,yellow}
    output wire       relay_out_channel_one,      // Relay closed
    output wire       relay_out_channel_two,      // Relay closed
    output wire       network_channel_one,        // Output enable
    output wire       network_channel_two,        // Output enable
    output wire [1:0] limit_one,                  // Limit code ch one
    output wire [1:0] limit_two,                  // Limit code ch two
    output wire       setting_mode                // Setting mode active
);

    localparam [1:0] ST_NORM = 2'h0;
    localparam [1:0] ST_DISP = 2'h1;
    localparam [1:0] ST_SET  = 2'h2;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Flash count for a limit code
    function [2:0] flb_flashes;
        input [1:0] code;
        begin
            flb_flashes = `FLB_FLASH_MAX - {1'h0, code};
        end
    endfunction

    // Status colour in normal operation {g,r,y}
    function [2:0] flb_stat;
        input gf;
        input ov;
        input logd;
        input ph;
        begin
            if (gf)
                flb_stat = 3'h1;
            else if (ov && logd)
                flb_stat = ph ? 3'h2 : 3'h1;
            else if (ov)
                flb_stat = 3'h2;
            else if (logd)
                flb_stat = {2'h0, ph};
            else
                flb_stat = 3'h0;
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    wire [6:0] raw = {overload_two_pin, overload_one_pin, gnd_fault_two_pin,
                      gnd_fault_one_pin, supply_low_pin, remote_reset_pos,
                      button_pin};
    reg  [6:0] s1_q;
    reg  [6:0] s2_q;

    // Two flops per pin
    always @(posedge sys_clk) begin
        if (!nrst) begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    wire       btn_s = s2_q[`FLB_IN_BTN];
    wire       rem_s = s2_q[`FLB_IN_REM];
    wire       low_s = s2_q[`FLB_IN_LOW];
    wire [1:0] gf    = {s2_q[`FLB_IN_GF2] & (DUAL != 0), s2_q[`FLB_IN_GF1]};
    wire [1:0] ov    = {s2_q[`FLB_IN_OV2] & (DUAL != 0), s2_q[`FLB_IN_OV1]};

    // ----------------------------------------
    // Button debounce and press timing
    // ----------------------------------------
    reg  [27:0] deb_q;
    reg         btn_q;
    reg  [27:0] prs_q;
    reg  [27:0] pu_q;
    reg         pwr_q;
    reg         short_q;
    reg         long_q;
    reg         plong_q;
    wire        rel = btn_q && (btn_s == 1'h0) && (deb_q >= N_DEB - 28'h1);

    // Debounce, duration count, release classification
    always @(posedge sys_clk) begin
        if (!nrst) begin
            deb_q   <= 28'h0;
            btn_q   <= 1'h0;
            prs_q   <= 28'h0;
            pu_q    <= 28'h0;
            pwr_q   <= 1'h1;
            short_q <= 1'h0;
            long_q  <= 1'h0;
            plong_q <= 1'h0;
        end else begin
            short_q <= 1'h0;
            long_q  <= 1'h0;
            plong_q <= 1'h0;
            if (btn_s != btn_q) begin
                if (deb_q >= N_DEB - 28'h1) begin
                    btn_q <= btn_s;
                    deb_q <= 28'h0;
                end else begin
                    deb_q <= deb_q + 28'h1;
                end
            end else begin
                deb_q <= 28'h0;
            end
            if (btn_q && prs_q <= N_LMAX)
                prs_q <= prs_q + 28'h1;
            else if (!btn_q)
                prs_q <= 28'h0;
            // Power-up window closes if button is not held
            if (pwr_q && pu_q < N_PWRUP)
                pu_q <= pu_q + 28'h1;
            else if (pwr_q && !btn_q)
                pwr_q <= 1'h0;
            if (rel) begin
                pwr_q <= 1'h0;
                if (prs_q < N_SHORT)
                    short_q <= 1'h1;
                else if (prs_q >= N_LMIN && prs_q <= N_LMAX) begin
                    long_q  <= ~pwr_q;
                    plong_q <= pwr_q;
                end
            end
        end
    end

    // ----------------------------------------
    // Remote reset filter
    // ----------------------------------------
    reg  [27:0] hi_q;
    reg  [27:0] lo_q;
    reg         arm_q;
    reg         rclr_q;

    // High pulse length and low re-arm time
    always @(posedge sys_clk) begin
        if (!nrst) begin
            hi_q   <= 28'h0;
            lo_q   <= 28'h0;
            arm_q  <= 1'h0;
            rclr_q <= 1'h0;
        end else begin
            rclr_q <= 1'h0;
            if (rem_s) begin
                lo_q <= 28'h0;
                if (hi_q < N_REM)
                    hi_q <= hi_q + 28'h1;
                if (hi_q == N_REM - 28'h1 && arm_q) begin
                    rclr_q <= 1'h1;
                    arm_q  <= 1'h0;
                end
            end else begin
                hi_q <= 28'h0;
                if (lo_q < N_REM)
                    lo_q <= lo_q + 28'h1;
                if (lo_q == N_REM - 28'h1)
                    arm_q <= 1'h1;
            end
        end
    end

    // ----------------------------------------
    // Blink phase generators
    // ----------------------------------------
    reg  [27:0] c1_q;
    reg         ph1_q;
    reg  [27:0] c4_q;
    reg         ph4_q;
    reg         restart;
    wire        c4_end = (c4_q == N_4HZ - 28'h1);
    wire        slot_tick = c4_end && ph4_q;

    // 1 Hz and 4 Hz square waves
    always @(posedge sys_clk) begin
        if (!nrst) begin
            c1_q  <= 28'h0;
            ph1_q <= 1'h1;
            c4_q  <= 28'h0;
            ph4_q <= 1'h1;
        end else begin
            if (c1_q == N_1HZ - 28'h1) begin
                c1_q  <= 28'h0;
                ph1_q <= ~ph1_q;
            end else begin
                c1_q <= c1_q + 28'h1;
            end
            if (restart) begin
                c4_q  <= 28'h0;
                ph4_q <= 1'h1;
            end else if (c4_end) begin
                c4_q  <= 28'h0;
                ph4_q <= ~ph4_q;
            end else begin
                c4_q <= c4_q + 28'h1;
            end
        end
    end

    // ----------------------------------------
    // Mode control, limits and fault logs
    // ----------------------------------------
    reg  [1:0] st_q;
    reg        set_q;
    reg        sel_q;
    reg  [2:0] slot_q;
    reg  [1:0] edit_q;
    reg  [1:0] lim1_q;
    reg  [1:0] lim2_q;
    reg  [1:0] log_q;
    reg        simch_q;
    reg  [1:0] sim;
    reg        clr;
    wire       signalled = (|log_q) || (|gf);
    wire [1:0] cur_lim = sel_q ? lim2_q : lim1_q;
    wire [2:0] nfl = flb_flashes((st_q == ST_SET) ? edit_q : cur_lim);

    // Clear and simulate requests
    always @* begin
        restart = 1'h0;
        sim     = 2'h0;
        clr     = rclr_q;
        if (st_q == ST_NORM) begin
            if (short_q && signalled)
                clr = 1'h1;
            if (short_q && !signalled)
                restart = 1'h1;
            if (long_q)
                sim[simch_q] = 1'h1;
        end
        if (plong_q || (st_q == ST_SET && (short_q || long_q)))
            restart = 1'h1;
    end

    // Mode state machine and limit storage
    always @(posedge sys_clk) begin
        if (!nrst) begin
            st_q    <= ST_NORM;
            set_q   <= 1'h0;
            sel_q   <= 1'h0;
            slot_q  <= 3'h0;
            edit_q  <= `FLB_LIM_RST;
            lim1_q  <= `FLB_LIM_RST;
            lim2_q  <= `FLB_LIM_RST;
            simch_q <= 1'h0;
        end else begin
            case (st_q)
                ST_NORM: begin
                    if (plong_q) begin
                        st_q   <= ST_SET;
                        set_q  <= 1'h1;
                        sel_q  <= 1'h0;
                        slot_q <= 3'h0;
                        edit_q <= lim1_q;
                    end else if (short_q && !signalled) begin
                        st_q   <= ST_DISP;
                        sel_q  <= 1'h0;
                        slot_q <= 3'h0;
                    end else if (long_q && DUAL != 0) begin
                        simch_q <= ~simch_q;
                    end
                end
                ST_DISP: begin
                    if (slot_tick) begin
                        if (slot_q == nfl) begin
                            slot_q <= 3'h0;
                            if (!sel_q && DUAL != 0)
                                sel_q <= 1'h1;
                            else begin
                                sel_q <= 1'h0;
                                st_q  <= ST_NORM;
                            end
                        end else begin
                            slot_q <= slot_q + 3'h1;
                        end
                    end
                end
                ST_SET: begin
                    if (short_q) begin
                        edit_q <= edit_q + 2'h1;
                        slot_q <= 3'h0;
                    end else if (long_q) begin
                        slot_q <= 3'h0;
                        if (sel_q)
                            lim2_q <= edit_q;
                        else
                            lim1_q <= edit_q;
                        if (!sel_q && DUAL != 0) begin
                            sel_q  <= 1'h1;
                            edit_q <= lim2_q;
                        end else begin
                            sel_q <= 1'h0;
                            st_q  <= ST_NORM;
                            set_q <= 1'h0;
                        end
                    end else if (slot_tick) begin
                        if (slot_q == nfl + 3'h1)
                            slot_q <= 3'h0;
                        else
                            slot_q <= slot_q + 3'h1;
                    end
                end
                default: begin
                    st_q  <= ST_NORM;
                    set_q <= 1'h0;
                end
            endcase
        end
    end

    // Fault logs: detection or simulation beats a clear
    always @(posedge sys_clk) begin
        if (!nrst) begin
            log_q <= 2'h0;
        end else begin
            log_q <= gf | sim | (log_q & ~({2{clr}} & ~gf));
        end
    end

    // ----------------------------------------
    // Indicator and output registers
    // ----------------------------------------
    reg        pwr_led_q;
    reg  [2:0] led1_q;
    reg  [2:0] led2_q;
    reg  [1:0] net_q;
    reg  [2:0] fl;

    // Flash pattern of the selected channel
    always @* begin
        fl = 3'h0;
        if (ph4_q && slot_q < nfl)
            fl = 3'h4;
        else if (ph4_q && st_q == ST_SET && slot_q == nfl)
            fl = 3'h2;
    end

    // LED colours and network enables
    always @(posedge sys_clk) begin
        if (!nrst) begin
            pwr_led_q <= 1'h0;
            led1_q    <= 3'h0;
            led2_q    <= 3'h0;
            net_q     <= 2'h0;
        end else begin
            if (low_s)
                pwr_led_q <= ph1_q;
            else if (st_q == ST_SET)
                pwr_led_q <= ph4_q;
            else
                pwr_led_q <= 1'h1;
            net_q <= low_s ? 2'h0 : {DUAL != 0, 1'h1};
            if (st_q != ST_NORM) begin
                led1_q <= sel_q ? 3'h0 : fl;
                led2_q <= sel_q ? fl : 3'h0;
            end else begin
                led1_q <= flb_stat(gf[0], ov[0], log_q[0], ph1_q);
                led2_q <= flb_stat(gf[1], ov[1], log_q[1], ph1_q);
            end
        end
    end

    assign power_indicator        = pwr_led_q;
    assign channel_one_status_led = led1_q;
    assign channel_two_status_led = led2_q;
    assign relay_out_channel_one  = log_q[0];
    assign relay_out_channel_two  = log_q[1];
    assign network_channel_one    = net_q[0];
    assign network_channel_two    = net_q[1];
    assign limit_one              = lim1_q;
    assign limit_two              = lim2_q;
    assign setting_mode           = set_q;

endmodule // flb_ctrl

`default_nettype wire

// ===== flb_map.vh
`ifndef FLB_MAP_VH
`define FLB_MAP_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define FLB_CLK_KHZ     25000
`define FLB_CW          28
`define FLB_T_DEB_MS    20
`define FLB_T_SHORT_MS  1000
`define FLB_T_LMIN_MS   3000
`define FLB_T_LMAX_MS   5000
`define FLB_T_REM_MS    100
`define FLB_T_PWRUP_MS  500
`define FLB_T_1HZ_MS    500
`define FLB_T_4HZ_MS    125
// Cycles from milliseconds, exact at 25 MHz
`define FLB_N(ms)       ((ms) * `FLB_CLK_KHZ)

// ----------------------------------------
// Current limit codes and flash counts
// ----------------------------------------
`define FLB_LIM_4A0     2'h0
`define FLB_LIM_3A5     2'h1
`define FLB_LIM_3A0     2'h2
`define FLB_LIM_2A5     2'h3
`define FLB_LIM_RST     `FLB_LIM_4A0
`define FLB_FLASH_MAX   3'h4

// ----------------------------------------
// Input bit positions in the sync vector
// ----------------------------------------
`define FLB_IN_BTN      0
`define FLB_IN_REM      1
`define FLB_IN_LOW      2
`define FLB_IN_GF1      3
`define FLB_IN_GF2      4
`define FLB_IN_OV1      5
`define FLB_IN_OV2      6

`endif

// ===== flb_ctrl_assertions.sv
`default_nettype none
// ----------------------------------------
// Checker on the control block's pins
// ----------------------------------------
module flb_ctrl_assertions (
    input wire logic       sys_clk,                // Clock
    input wire logic       nrst,                   // Reset, low
    input wire logic       button_pin,             // Button
    input wire logic       remote_reset_pos,       // Remote reset
    input wire logic       supply_low_pin,         // Supply low
    input wire logic       gnd_fault_one_pin,      // Fault one
    input wire logic       gnd_fault_two_pin,      // Fault two
    input wire logic       overload_one_pin,       // Overload one
    input wire logic       overload_two_pin,       // Overload two
    input wire logic       power_indicator,        // Power LED
    input wire logic [2:0] channel_one_status_led, // LED one
    input wire logic [2:0] channel_two_status_led, // LED two
    input wire logic       relay_out_channel_one,  // Relay one
    input wire logic       relay_out_channel_two,  // Relay two
    input wire logic       network_channel_one,    // Net one
    input wire logic       network_channel_two,    // Net two
    input wire logic [1:0] limit_one,              // Limit one
    input wire logic [1:0] limit_two,              // Limit two
    input wire logic       setting_mode            // Setting mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Relays close on live faults, two sync flops allowed
    chk_relay_one_close: assert property (gnd_fault_one_pin [*4] |=> relay_out_channel_one)
        else $error("relay one open during fault");
    chk_relay_two_close: assert property (gnd_fault_two_pin [*4] |=> relay_out_channel_two)
        else $error("relay two open during fault");
    // A live fault keeps its log
    chk_clear_blocked: assert property ((gnd_fault_one_pin [*3]) ##0 relay_out_channel_one
        |=> relay_out_channel_one) else $error("log cleared during live fault");
    // Status colour for live fault and plain overload
    chk_fault_yellow: assert property ((gnd_fault_one_pin && !setting_mode) [*5]
        |=> channel_one_status_led == 3'h1) else $error("no steady yellow");
    chk_overload_red: assert property ((overload_one_pin && !gnd_fault_one_pin
        && !relay_out_channel_one && !setting_mode) [*5] |=> channel_one_status_led == 3'h2)
        else $error("no steady red");
    // Supply level drives power LED and network enables
    chk_power_steady: assert property ((!supply_low_pin && !setting_mode) [*4]
        |=> power_indicator) else $error("power LED not steady");
    chk_net_off_low: assert property (supply_low_pin [*4]
        |=> !network_channel_one && !network_channel_two) else $error("net on at low supply");
    chk_net_on_ok: assert property (!supply_low_pin [*4] |=> network_channel_one)
        else $error("net off at good supply");
    // Limits change only out of setting mode's store
    chk_limit_kept: assert property (!setting_mode [*2] |=> $stable(limit_one))
        else $error("limit changed outside setting");

    // Main scenarios reached
    cov_setting: cover property ($rose(setting_mode));
    cov_relay: cover property ($rose(relay_out_channel_two));
    cov_green: cover property ($rose(channel_one_status_led[2]));
endmodule // flb_ctrl_assertions
`default_nettype wire

// ===== flb_operator.sv
`default_nettype none
// ----------------------------------------
// Operator: push-button and remote line
// ----------------------------------------
module flb_operator (
    input  wire logic sys_clk,          // Clock
    output var  logic button_pin,       // Button, high pressed
    output var  logic remote_reset_pos  // Remote reset level
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle: released, line low
    initial begin
        button_pin = 1'b0;
        remote_reset_pos = 1'b0;
    end

    // Press for hold cycles, then wait after cycles
    task automatic press(input int hold, input int after);
        @(negedge sys_clk);
        button_pin = 1'b1;
        repeat (hold) @(negedge sys_clk);
        button_pin = 1'b0;
        repeat (after) @(negedge sys_clk);
    endtask

    // Low span, high span, then low again
    task automatic remote(input int low, input int high);
        remote_reset_pos = 1'b0;
        repeat (low) @(negedge sys_clk);
        remote_reset_pos = 1'b1;
        repeat (high) @(negedge sys_clk);
        remote_reset_pos = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
endmodule // flb_operator
`default_nettype wire

// ===== test_flb_ctrl.sv
`default_nettype none
module test_flb_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk, nrst, supply_low_pin, power_indicator, setting_mode;
    logic       gnd_fault_one_pin, gnd_fault_two_pin, overload_one_pin, overload_two_pin;
    logic       button_pin, remote_reset_pos, relay_out_channel_one, relay_out_channel_two;
    logic       network_channel_one, network_channel_two;
    logic [2:0] channel_one_status_led, channel_two_status_led;
    logic [1:0] limit_one, limit_two, s;
    int         fail_count, n_compared, f;

    flb_ctrl #(.N_SHORT(28'h28), .N_LMIN(28'h64), .N_LMAX(28'hA0), .N_REM(28'h14),
        .N_1HZ(28'h10)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .button_pin(button_pin),
        .remote_reset_pos(remote_reset_pos), .supply_low_pin(supply_low_pin),
        .gnd_fault_one_pin(gnd_fault_one_pin), .gnd_fault_two_pin(gnd_fault_two_pin),
        .overload_one_pin(overload_one_pin), .overload_two_pin(overload_two_pin),
        .power_indicator(power_indicator), .channel_one_status_led(channel_one_status_led),
        .channel_two_status_led(channel_two_status_led),
        .relay_out_channel_one(relay_out_channel_one),
        .relay_out_channel_two(relay_out_channel_two), .network_channel_one(network_channel_one),
        .network_channel_two(network_channel_two), .limit_one(limit_one),
        .limit_two(limit_two), .setting_mode(setting_mode));
    flb_operator op (.sys_clk(sys_clk), .button_pin(button_pin),
        .remote_reset_pos(remote_reset_pos));

    // ----------------------------------------
    // Clock, checks, ending
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Colours a and b seen on channel one within 40 cycles
    task automatic watch(input logic [2:0] a, input logic [2:0] b);
        s = 2'b00;
        repeat (40) begin
            @(negedge sys_clk);
            if (channel_one_status_led === a) s[1] = 1'b1;
            if (channel_one_status_led === b) s[0] = 1'b1;
        end
    endtask

    // Count power LED changes over n cycles
    task automatic flips(input int n);
        logic p;
        f = 0;
        p = power_indicator;
        repeat (n) begin
            @(negedge sys_clk);
            if (power_indicator !== p) f++;
            p = power_indicator;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_setting();
        op.press(130, 12);
        check(setting_mode, 1'b1);
        flips(48);
        check(f >= 4, 1'b1);
        op.press(15, 12);
        op.press(130, 12);
        check({limit_one, setting_mode}, 3'h3);
        repeat (3) op.press(15, 12);
        op.press(130, 12);
        check({limit_two, setting_mode}, 3'h6);
        $display("setting test done");
    endtask

    task automatic t_display();
        int g1, g2;
        logic p1, p2;
        g1 = 0;
        g2 = 0;
        p1 = 1'b0;
        p2 = 1'b0;
        op.press(15, 0);
        repeat (250) begin
            @(negedge sys_clk);
            if (channel_one_status_led[2] && !p1) g1++;
            if (channel_two_status_led[2] && !p2) g2++;
            p1 = channel_one_status_led[2];
            p2 = channel_two_status_led[2];
        end
        check(g1, 8'h3);
        check(g2, 8'h1);
        check({channel_one_status_led, relay_out_channel_one}, 4'h0);
        $display("display test done");
    endtask

    task automatic t_simulate();
        op.press(130, 12);
        check({relay_out_channel_one, relay_out_channel_two}, 2'h2);
        watch(3'h1, 3'h0);
        check(s, 2'h3);
        op.press(130, 12);
        check({relay_out_channel_one, relay_out_channel_two}, 2'h3);
        op.press(15, 12);
        check({relay_out_channel_one, relay_out_channel_two}, 2'h0);
        $display("simulate test done");
    endtask

    task automatic t_ground();
        gnd_fault_one_pin = 1'b1;
        wait_n(6);
        check({relay_out_channel_one, relay_out_channel_two, channel_one_status_led}, 5'h11);
        op.press(15, 12);
        op.remote(25, 25);
        check(relay_out_channel_one, 1'b1);
        gnd_fault_one_pin = 1'b0;
        watch(3'h1, 3'h0);
        check({s, relay_out_channel_one}, 3'h7);
        op.remote(25, 25);
        check(relay_out_channel_one, 1'b0);
        gnd_fault_one_pin = 1'b1;
        wait_n(6);
        gnd_fault_one_pin = 1'b0;
        wait_n(2);
        op.remote(5, 25);
        check(relay_out_channel_one, 1'b1);
        op.remote(25, 10);
        check(relay_out_channel_one, 1'b1);
        op.remote(25, 25);
        check(relay_out_channel_one, 1'b0);
        $display("ground test done");
    endtask

    task automatic t_overload();
        overload_one_pin = 1'b1;
        wait_n(8);
        check({channel_one_status_led, relay_out_channel_one}, 4'h4);
        gnd_fault_one_pin = 1'b1;
        wait_n(6);
        gnd_fault_one_pin = 1'b0;
        watch(3'h2, 3'h1);
        check({s, relay_out_channel_one}, 3'h7);
        overload_one_pin = 1'b0;
        op.remote(25, 25);
        check(relay_out_channel_one, 1'b0);
        $display("overload test done");
    endtask

    task automatic t_supply();
        supply_low_pin = 1'b1;
        wait_n(6);
        check({network_channel_one, network_channel_two}, 2'h0);
        flips(40);
        check(f >= 2, 1'b1);
        supply_low_pin = 1'b0;
        wait_n(6);
        check({network_channel_one, network_channel_two, power_indicator}, 3'h7);
        $display("supply test done");
    endtask

    task automatic t_relays();
        gnd_fault_two_pin = 1'b1;
        wait_n(6);
        check({relay_out_channel_one, relay_out_channel_two}, 2'h1);
        gnd_fault_two_pin = 1'b0;
        op.remote(25, 25);
        overload_two_pin = 1'b1;
        wait_n(8);
        check({channel_two_status_led, relay_out_channel_two}, 4'h4);
        overload_two_pin = 1'b0;
        $display("relay test done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        fail_count = 0;
        n_compared = 0;
        nrst = 1'b0;
        supply_low_pin = 1'b0;
        gnd_fault_one_pin = 1'b0;
        gnd_fault_two_pin = 1'b0;
        overload_one_pin = 1'b0;
        overload_two_pin = 1'b0;
        wait_n(10);
        nrst = 1'b1;
        t_setting();
        t_display();
        t_simulate();
        t_relays();
        t_ground();
        t_overload();
        t_supply();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
endmodule // test_flb_ctrl

bind flb_ctrl flb_ctrl_assertions chk (.sys_clk(sys_clk), .nrst(nrst),
    .button_pin(button_pin), .remote_reset_pos(remote_reset_pos),
    .supply_low_pin(supply_low_pin), .gnd_fault_one_pin(gnd_fault_one_pin),
    .gnd_fault_two_pin(gnd_fault_two_pin), .overload_one_pin(overload_one_pin),
    .overload_two_pin(overload_two_pin), .power_indicator(power_indicator),
    .channel_one_status_led(channel_one_status_led),
    .channel_two_status_led(channel_two_status_led),
    .relay_out_channel_one(relay_out_channel_one), .relay_out_channel_two(relay_out_channel_two),
    .network_channel_one(network_channel_one), .network_channel_two(network_channel_two),
    .limit_one(limit_one), .limit_two(limit_two), .setting_mode(setting_mode));
`default_nettype wire
